// ---- hw/sadc_top.sv ----
`timescale 1ns/1ps
module sadc_top
	import sadc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic conversion_start_n,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic narrow_lane_select,
	input wire logic low_pair_select,
	input wire logic [17:0] analog_code,
	output logic busy,
	output logic sample_hold,
	output logic [17:0] result_bus_out,
	output logic result_bus_oe
);

	////////////////////////////////////////////////////////////////////////////
	// Reset release through two flops; assertion stays asynchronous.
	logic rst_meta_r, rst_sync_n_r;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_n_r <= rst_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; only the second stage and later copies feed logic.
	logic [4:0] pin_meta_r, pin_sync_r, pin_prev_r;

	always_ff @(posedge mclk or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			pin_meta_r <= PINS_IDLE;
			pin_sync_r <= PINS_IDLE;
			pin_prev_r <= PINS_IDLE;
		end else begin
			pin_meta_r <= {conversion_start_n, cs_n, rd_n, narrow_lane_select, low_pair_select};
			pin_sync_r <= pin_meta_r;
			pin_prev_r <= pin_sync_r;
		end
	end

	logic conv_s, cs_s, rd_s, narrow_s, lowpair_s;
	logic conv_fall, cs_fall, start_ok;

	// Edges are seen between the second stage and its delayed copy.
	assign conv_s = pin_sync_r[PIN_CONV];
	assign cs_s = pin_sync_r[PIN_CS];
	assign rd_s = pin_sync_r[PIN_RD];
	assign narrow_s = pin_sync_r[PIN_NARROW];
	assign lowpair_s = pin_sync_r[PIN_LOWPAIR];
	assign conv_fall = pin_prev_r[PIN_CONV] & ~conv_s;
	assign cs_fall = pin_prev_r[PIN_CS] & ~cs_s;
	assign start_ok = conv_fall & ~cs_s;

	////////////////////////////////////////////////////////////////////////////
	// Output word slicing for the three bus widths.
	function automatic logic [17:0] sadc_slice(input logic [17:0] w, input logic nar, input logic lp);
		logic [17:0] o;
		o = BUS_ALL_ONES;
		case ({nar, lp})
			2'h0: o = w;
			2'h1: o[3:2] = w[1:0];
			2'h2: o[17:10] = w[9:2];
			2'h3: o[11:10] = w[1:0];
			default: o = BUS_ALL_ONES;
		endcase
		return o;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Conversion control. The system clock stands in for the internal
	// oscillator, so nothing from the host paces the search.
	sadc_state_t state_r, state_nxt;
	logic busy_r, busy_nxt;
	logic hold_r, hold_nxt;
	logic [17:0] held_r, held_nxt;
	logic [17:0] result_r, result_nxt;
	logic [17:0] bus_r, bus_nxt;
	logic oe_r, oe_nxt;
	logic sar_load, sar_abort, sar_done;
	logic [17:0] sar_result;

	always_comb begin
		state_nxt = state_r;
		busy_nxt = busy_r;
		hold_nxt = hold_r;
		held_nxt = held_r;
		result_nxt = result_r;
		sar_load = 1'b0;
		sar_abort = 1'b0;
		case (state_r)
			SADC_SAMPLE, SADC_DONE_IDLE: begin
				if (start_ok) begin
					state_nxt = SADC_CONVERT;
					busy_nxt = 1'b1;
					hold_nxt = 1'b1;
					held_nxt = analog_code;
					sar_load = 1'b1;
				end else if (state_r == SADC_DONE_IDLE && cs_fall) begin
					state_nxt = SADC_SAMPLE;
					hold_nxt = 1'b0;
				end
			end
			SADC_CONVERT: begin
				if (start_ok || cs_fall) begin
					// Self-clear reset: result latch zeroed, busy dropped, sampling restarts.
					state_nxt = SADC_SAMPLE;
					busy_nxt = 1'b0;
					hold_nxt = 1'b0;
					result_nxt = RESULT_RST;
					sar_abort = 1'b1;
				end else if (sar_done) begin
					busy_nxt = 1'b0;
					result_nxt = sar_result;
					// With select high the input stays frozen until select falls.
					state_nxt = cs_s ? SADC_DONE_IDLE : SADC_SAMPLE;
					hold_nxt = cs_s;
				end
			end
			default: begin
				state_nxt = SADC_SAMPLE;
				busy_nxt = 1'b0;
				hold_nxt = 1'b0;
			end
		endcase
		// Slices follow the selects live, so a held read strobe works too.
		bus_nxt = sadc_slice(result_r, narrow_s, lowpair_s);
		oe_nxt = ~cs_s & ~rd_s;
	end

	// Registers of the control group.
	always_ff @(posedge mclk or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			state_r <= SADC_SAMPLE;
			busy_r <= 1'b0;
			hold_r <= 1'b0;
			held_r <= RESULT_RST;
			result_r <= RESULT_RST;
			bus_r <= RESULT_RST;
			oe_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			busy_r <= busy_nxt;
			hold_r <= hold_nxt;
			held_r <= held_nxt;
			result_r <= result_nxt;
			bus_r <= bus_nxt;
			oe_r <= oe_nxt;
		end
	end

	// Search engine; it finishes CONV_CYCLES after the load.
	// The target is fed the value being captured, since the held copy only updates at the load edge.
	sadc_sar u_sar (
		.mclk(mclk),
		.rst_sync_n(rst_sync_n_r),
		.load(sar_load),
		.abort(sar_abort),
		.held_code(held_nxt),
		.result(sar_result),
		.done(sar_done)
	);

	assign busy = busy_r;
	assign sample_hold = hold_r;
	assign result_bus_out = bus_r;
	assign result_bus_oe = oe_r;

	////////////////////////////////////////////////////////////////////////////
	// Checks. A counter measures busy so its length is bounded exactly.
	logic [3:0] busy_cnt_r;

	always_ff @(posedge mclk or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			busy_cnt_r <= 4'h0;
		end else begin
			busy_cnt_r <= busy_r ? busy_cnt_r + 4'h1 : 4'h0;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_sync_n_r);

	a_busy_rise: assert property (start_ok && state_r != SADC_CONVERT |=> busy_r) else $error("busy missed start");
	a_hold_start: assert property (start_ok && !busy_r |=> hold_r && held_r == $past(analog_code))
		else $error("hold missed start");
	a_busy_len: assert property (busy_cnt_r <= 4'(CONV_CYCLES + 1)) else $error("busy too long");
	a_busy_full: assert property ($fell(busy_r) |-> $past(sar_done) || $past(sar_abort))
		else $error("busy shape wrong");
	a_abort_clear: assert property (state_r == SADC_CONVERT && (start_ok || cs_fall) |=> !busy_r && result_r == 18'h00000)
		else $error("abort did not clear");
	a_code_map: assert property (sar_done |-> sar_result == held_r) else $error("code map wrong");
	a_bus_enable: assert property ((!cs_s && !rd_s) |=> result_bus_oe) else $error("bus not driven");
	a_bus_float: assert property ((cs_s || rd_s) |=> !result_bus_oe) else $error("bus driven illegally");
	a_full_word: assert property (!narrow_s && !lowpair_s |=> result_bus_out == $past(result_r))
		else $error("full word wrong");
	a_low_pair16: assert property (!narrow_s && lowpair_s |=> result_bus_out == {14'h3FFF, $past(result_r[1:0]), 2'h3})
		else $error("low pair wrong");
	a_byte_mid: assert property (narrow_s && !lowpair_s |=> result_bus_out[17:10] == $past(result_r[9:2]))
		else $error("middle byte wrong");
	a_result_keep: assert property (!sar_done && !sar_abort |=> $stable(result_r)) else $error("result changed");
	a_resample: assert property (state_r == SADC_CONVERT && sar_done && !cs_s && !start_ok |=> !hold_r && !busy_r)
		else $error("sampling not resumed");

	c_full_conv: cover property ($rose(busy_r) ##[1:8] $fell(busy_r));
	c_abort: cover property (state_r == SADC_CONVERT && cs_fall);
	c_byte_low: cover property (result_bus_oe && narrow_s && lowpair_s);

endmodule

// ---- inc/sadc_pkg.sv ----
package sadc_pkg;

	// Result word width and the SAR stepping plan.
	localparam int RES_W = 18;
	localparam int BITS_PER_STEP = 3;
	localparam int SAR_STEPS = RES_W / BITS_PER_STEP;

	// Timing figures in nanoseconds, as printed.
	localparam int CLK_PERIOD_NS = 100;
	localparam int CONV_TIME_NS = 650;
	localparam int START_LOW_MIN_NS = 20;
	localparam int QUIET_BEFORE_NS = 50;
	localparam int QUIET_AFTER_NS = 40;
	localparam int ACQ_MIN_NS = 320;

	// The conversion time is a nominal figure; it rounds down, never below one cycle.
	localparam int CONV_CYCLES_RAW = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;

	// Reset values and codes of the output word.
	localparam logic [17:0] RESULT_RST = 18'h00000;
	localparam logic [17:0] CODE_POS_FS = 18'h1FFFF;
	localparam logic [17:0] CODE_MID = 18'h00000;
	localparam logic [17:0] CODE_MID_M1 = 18'h3FFFF;
	localparam logic [17:0] CODE_NEG_FS = 18'h20000;
	localparam logic [17:0] BUS_ALL_ONES = 18'h3FFFF;

	// Field positions of the synchronised pin vector.
	localparam int PIN_CONV = 4;
	localparam int PIN_CS = 3;
	localparam int PIN_RD = 2;
	localparam int PIN_NARROW = 1;
	localparam int PIN_LOWPAIR = 0;
	localparam logic [4:0] PINS_IDLE = 5'h1C;

	typedef enum logic [1:0] {
		SADC_SAMPLE,
		SADC_CONVERT,
		SADC_DONE_IDLE
	} sadc_state_t;

endpackage

// ---- hw/sadc_sar.sv ----
`timescale 1ns/1ps
module sadc_sar
	import sadc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_sync_n,
	input wire logic load,
	input wire logic abort,
	input wire logic [17:0] held_code,
	output logic [17:0] result,
	output logic done
);

	logic [17:0] trial_r, trial_nxt;
	logic [17:0] target_r, target_nxt;
	logic [2:0] step_r, step_nxt;
	logic run_r, run_nxt;
	logic done_r, done_nxt;

	////////////////////////////////////////////////////////////////////////////
	// The search runs in offset binary so an unsigned compare works; the top
	// bit is flipped back at the end, giving the two's complement code map.
	always_comb begin
		logic [17:0] t;
		t = trial_r;
		trial_nxt = trial_r;
		target_nxt = target_r;
		step_nxt = step_r;
		run_nxt = run_r;
		done_nxt = 1'b0;
		if (abort) begin
			run_nxt = 1'b0;
		end else if (load) begin
			target_nxt = held_code ^ CODE_NEG_FS;
			trial_nxt = RESULT_RST;
			step_nxt = 3'h0;
			run_nxt = 1'b1;
		end else if (run_r) begin
			// Three bit decisions per clock keep the whole search inside the conversion time.
			for (int b = 0; b < BITS_PER_STEP; b++) begin
				t[RES_W - 1 - (int'(step_r) * BITS_PER_STEP) - b] = 1'b1;
				if (t > target_r) begin
					t[RES_W - 1 - (int'(step_r) * BITS_PER_STEP) - b] = 1'b0;
				end
			end
			trial_nxt = t;
			step_nxt = step_r + 3'h1;
			if (int'(step_r) == SAR_STEPS - 1) begin
				run_nxt = 1'b0;
				done_nxt = 1'b1;
			end
		end
	end

	// State registers of the search.
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			trial_r <= RESULT_RST;
			target_r <= RESULT_RST;
			step_r <= 3'h0;
			run_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			trial_r <= trial_nxt;
			target_r <= target_nxt;
			step_r <= step_nxt;
			run_r <= run_nxt;
			done_r <= done_nxt;
		end
	end

	assign result = trial_r ^ CODE_NEG_FS;
	assign done = done_r;

endmodule

// ---- sim/sadc_host.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Host controller model: it changes pins 10 ns after a rising edge and resolves the bus wire.
module sadc_host
	import sadc_pkg::*;
(
	input wire logic mclk,
	output logic conversion_start_n = 1'b1,
	output logic cs_n = 1'b1,
	output logic rd_n = 1'b1,
	output logic narrow_lane_select = 1'b0,
	output logic low_pair_select = 1'b0,
	output logic [17:0] analog_code = 18'h00000,
	input wire logic [17:0] result_bus_out,
	input wire logic result_bus_oe,
	output logic [17:0] result_bus
);
	logic [17:0] last_r = 18'h00000;

	// A released bus shows the inverse of its last value, so stale data never passes for a read.
	always @(posedge mclk) begin
		if (result_bus_oe) begin
			last_r <= result_bus_out;
		end
	end
	assign result_bus = result_bus_oe ? result_bus_out : ~last_r;

	// Sets the read pins, then lets w edges pass so the registered outputs have settled.
	task automatic set_pins(input logic cs, input logic rd, input logic nar, input logic lp, input int w);
		@(posedge mclk);
		#10;
		cs_n = cs;
		rd_n = rd;
		narrow_lane_select = nar;
		low_pair_select = lp;
		repeat (w) @(posedge mclk);
		#5;
	endtask

	// Start strobe with read held off around the edge; a zero acq is only used to abort on purpose.
	task automatic start(input logic [17:0] code, input logic cs, input logic cs_after, input int acq);
		repeat (acq) @(posedge mclk);
		@(posedge mclk);
		#10;
		analog_code = code;
		cs_n = cs;
		rd_n = 1'b1;
		@(posedge mclk);
		#10;
		conversion_start_n = 1'b0;
		repeat (3) @(posedge mclk);
		#10;
		conversion_start_n = 1'b1;
		cs_n = cs_after;
	endtask
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb
	import sadc_pkg::*;
;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic conversion_start_n, cs_n, rd_n, nar, lp, busy, sample_hold, result_bus_oe;
	logic [17:0] analog_code, result_bus_out, result_bus;
	int err_count = 0;
	int n_checks = 0;

	// Free-running 10 MHz clock.
	always #50 mclk = ~mclk;

	sadc_host u_host (.mclk(mclk), .conversion_start_n(conversion_start_n), .cs_n(cs_n), .rd_n(rd_n),
		.narrow_lane_select(nar), .low_pair_select(lp), .analog_code(analog_code),
		.result_bus_out(result_bus_out), .result_bus_oe(result_bus_oe), .result_bus(result_bus));
	sadc_top u_dut (.mclk(mclk), .rst_n(rst_n), .conversion_start_n(conversion_start_n), .cs_n(cs_n),
		.rd_n(rd_n), .narrow_lane_select(nar), .low_pair_select(lp), .analog_code(analog_code),
		.busy(busy), .sample_hold(sample_hold), .result_bus_out(result_bus_out), .result_bus_oe(result_bus_oe));

	////////////////////////////////////////////////////////////
	// Shared comparison and the verdict.
	task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic end_sim();
		if (err_count == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Expected bus image per select pair; lines that carry no result bits read as ones.
	function automatic logic [17:0] slice(input logic [17:0] r, input logic n, input logic l);
		case ({n, l})
			2'b00: slice = r;
			2'b01: slice = {14'h3FFF, r[1:0], 2'h3};
			2'b10: slice = {r[9:2], 10'h3FF};
			default: slice = {6'h3F, r[1:0], 10'h3FF};
		endcase
	endfunction

	////////////////////////////////////////////////////////////
	// One conversion; busy is counted in edges from the one where it rose to the one where it fell.
	task automatic conv(input logic [17:0] code, input logic cs_after);
		int k;
		int n;
		k = 0;
		n = 0;
		u_host.start(code, 1'b0, cs_after, 4);
		while (busy !== 1'b1 && k < 4) begin
			@(posedge mclk);
			#5;
			k++;
		end
		chk(18'(sample_hold), 18'h00001, "hold");
		while (busy === 1'b1 && n < 20) begin
			@(posedge mclk);
			#5;
			n++;
		end
		chk(18'(n), 18'(CONV_CYCLES + 1), "busy length");
	endtask

	task automatic t_codes();
		logic [17:0] codes [4];
		codes = '{CODE_POS_FS, CODE_MID, CODE_MID_M1, CODE_NEG_FS};
		foreach (codes[i]) begin
			conv(codes[i], 1'b0);
			chk(18'(sample_hold), 18'h00000, "sampling");
			u_host.set_pins(1'b0, 1'b0, 1'b0, 1'b0, 4);
			chk(result_bus, codes[i], "word");
			u_host.set_pins(1'b0, 1'b1, 1'b0, 1'b0, 4);
			chk(18'(result_bus_oe), 18'h00000, "rd high");
		end
		u_host.set_pins(1'b1, 1'b0, 1'b0, 1'b0, 4);
		chk(18'(result_bus_oe), 18'h00000, "cs high");
	endtask

	// First pass holds read low and only moves the selects, second toggles read between words.
	task automatic t_slices();
		conv(18'h2C6B5, 1'b0);
		for (int t = 0; t < 2; t++) begin
			for (int s = 0; s < 4; s++) begin
				if (t == 1) begin
					u_host.set_pins(1'b0, 1'b1, s[1], s[0], 1);
				end
				u_host.set_pins(1'b0, 1'b0, s[1], s[0], 4);
				chk(result_bus, slice(18'h2C6B5, s[1], s[0]), "slice");
			end
		end
		// An 8-bit host that wants only the top 16 bits stops after two reads.
		conv(18'h3A5C3, 1'b0);
		u_host.set_pins(1'b0, 1'b0, 1'b0, 1'b0, 4);
		chk(result_bus, slice(18'h3A5C3, 1'b0, 1'b0), "two-read high");
		u_host.set_pins(1'b0, 1'b0, 1'b1, 1'b0, 4);
		chk(result_bus, slice(18'h3A5C3, 1'b1, 1'b0), "two-read middle");
		u_host.set_pins(1'b0, 1'b1, 1'b0, 1'b0, 1);
		conv(18'h00F0F, 1'b0);
		u_host.set_pins(1'b0, 1'b0, 1'b0, 1'b0, 4);
		chk(result_bus, 18'h00F0F, "after two-read");
	endtask

	task automatic t_ignore();
		u_host.start(18'h12345, 1'b1, 1'b1, 4);
		repeat (8) begin
			@(posedge mclk);
			#5;
			chk(18'(busy), 18'h00000, "start unselected");
		end
	endtask

	task automatic t_abort_cs();
		u_host.start(18'h1ABCD, 1'b0, 1'b0, 4);
		u_host.set_pins(1'b1, 1'b1, 1'b0, 1'b0, 1);
		u_host.set_pins(1'b0, 1'b1, 1'b0, 1'b0, 4);
		chk(18'(busy), 18'h00000, "cs abort busy");
		u_host.set_pins(1'b0, 1'b0, 1'b0, 1'b0, 4);
		chk(result_bus, RESULT_RST, "cs abort clears");
	endtask

	task automatic t_abort_start();
		conv(18'h0F0F0, 1'b0);
		u_host.start(18'h15555, 1'b0, 1'b0, 4);
		u_host.start(18'h0AAAA, 1'b0, 1'b0, 0);
		@(posedge mclk);
		#5;
		chk(18'(busy), 18'h00000, "start abort busy");
		u_host.set_pins(1'b0, 1'b0, 1'b0, 1'b0, 4);
		chk(result_bus, RESULT_RST, "start abort clears");
	endtask

	// With select high at the end the input stays held until select falls.
	task automatic t_hold();
		conv(18'h0137F, 1'b1);
		chk(18'(sample_hold), 18'h00001, "held, cs high");
		u_host.set_pins(1'b0, 1'b1, 1'b0, 1'b0, 4);
		chk(18'(sample_hold), 18'h00000, "cs fall samples");
	endtask

	////////////////////////////////////////////////////////////
	// Reset for four cycles, then the scenarios; the watchdog cuts a hang short.
	initial begin
		repeat (4) @(posedge mclk);
		#10;
		rst_n = 1'b1;
		repeat (6) @(posedge mclk);
		#5;
		chk(18'({busy, sample_hold, result_bus_oe}), 18'h00000, "reset state");
		// The host throws away the first three results after power-up.
		repeat (3) conv(18'h00000, 1'b0);
		t_codes();
		t_slices();
		t_ignore();
		t_abort_cs();
		t_abort_start();
		t_hold();
		end_sim();
	end

	initial begin
		#200000;
		err_count++;
		end_sim();
	end
endmodule
